// [rtl/fbd_device.sv]
// Purpose: Device end: bus operation decoding, command latches, burst and bank control.
// Assumes: Pins arrive from logic on core_clk, so no synchroniser is used.
// Notes: Data outputs follow the pins one clock later.
// Operation
// - Command held in internal latches, not addressable.
// - Latched command drives the internal state machine.
// - Select plus gate low reads addressed word.
// - Select powers device; gate enables outputs once selected.
// - Write: select low, gate high, strobe low.
// - Outputs float on standby, disable or reset.
// - Power-up or reset enters array-read mode.
// - Array reads need no preceding command.
// - Array-read mode held until command written.
// - Identifier voltage, low byte 02h reads protection (code compares only the offset bits).
// - Bit 0 persistent, bit 1 dynamic protection.
// - Address-latch low with clock loads burst address.
// - Each clock with latch high advances burst (code also needs gate low).
// - Select high or reset low ends burst.
// - New latch pulse restarts burst at address.
// - Write-protect guards the two outermost sectors.
// - Program in busy bank, read other bank.
// - Host programs small bank, reads big bank.
// - Ready line low during algorithm or reset.
// - Host flags valid address with address-latch.
`timescale 1ns/1ns
`include "fbd_regs.svh"
module fbd_device #(
  parameter int ADDR_W = 8,
  parameter int SEC_W = 3,
  parameter int SMALL_SECTORS = 2,
  parameter logic [15:0] PROG_CYCLES = 16'h0064
) (
  input wire logic core_clk,
  input wire logic rst_b,
  fbd_if.device bus,
  output logic busy_q,
  output logic busy_bank_q,
  output logic [7:0] cmd_q
);
  localparam int NSEC = 1 << SEC_W;
  localparam logic [15:0] RST_CYC = 16'(`FBD_RESET_CYCLES);
  // The protection code sits in the offset bits below the sector field.
  localparam int OFF_W = ADDR_W - SEC_W;

  typedef struct packed {
    fbd_pkg::fbd_mode_e mode;
    logic [ADDR_W-1:0] burst_addr;
    logic burst_on;
    logic we_n_prev;
    logic [7:0] cmd;
    logic [ADDR_W-1:0] cmd_addr;
    logic [31:0] cmd_data;
    logic [15:0] busy_cnt;
    logic busy_bank;
    logic [NSEC-1:0] pers;
    logic [NSEC-1:0] dyn;
    logic [31:0] dq_out;
    logic dq_oe_n;
    logic rb_oe_n;
    logic busy_out;
  } fbd_dev_s;

  fbd_dev_s st_q;
  fbd_dev_s st_d;
  logic [31:0] mem [0:(1<<ADDR_W)-1];
  logic mem_we;

  function automatic logic [SEC_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1 -: SEC_W];
  endfunction

  // Bank 0 is the small bank made of the lowest sectors.
  function automatic logic bank_of(input logic [ADDR_W-1:0] a);
    return 32'(sector_of(a)) >= SMALL_SECTORS;
  endfunction

  function automatic logic prot_of(input logic [ADDR_W-1:0] a, input fbd_dev_s s,
                                   input logic wp_n);
    logic [SEC_W-1:0] sec;
    sec = sector_of(a);
    return s.pers[sec] | s.dyn[sec] |
           (!wp_n && (sec == '0 || sec == {SEC_W{1'b1}}));
  endfunction

  logic sel;
  logic wr_edge;
  logic rd;
  logic busy;
  logic [SEC_W-1:0] sec_in;
  logic [ADDR_W-1:0] word_addr;

  always_comb begin
    st_d = st_q;
    mem_we = 1'b0;
    sel = !bus.ce_n;
    sec_in = sector_of(bus.addr);
    busy = st_q.mode == fbd_pkg::FBD_MODE_BUSY;
    // A write is taken on the first cycle of a low strobe with the gate high.
    wr_edge = sel && !bus.we_n && bus.oe_n && st_q.we_n_prev;
    rd = sel && !bus.oe_n && bus.we_n;
    word_addr = (st_q.burst_on && bus.address_latch_n) ? st_q.burst_addr : bus.addr;
    st_d.we_n_prev = bus.we_n;
    if (!bus.reset_n) begin
      st_d.mode = fbd_pkg::FBD_MODE_RESET;
      st_d.busy_cnt = RST_CYC;
      st_d.burst_on = 1'b0;
      st_d.dyn = '0;
      st_d.dq_oe_n = 1'b1;
      st_d.we_n_prev = 1'b1;
    end else begin
      if (st_q.mode == fbd_pkg::FBD_MODE_BUSY || st_q.mode == fbd_pkg::FBD_MODE_RESET) begin
        if (st_q.busy_cnt <= 16'h0001) begin
          mem_we = busy;
          st_d.mode = fbd_pkg::FBD_MODE_READ;
          st_d.busy_cnt = '0;
        end else begin
          st_d.busy_cnt = st_q.busy_cnt - 16'h0001;
        end
      end
      // Burst address control runs on the rising clock edge.
      if (!sel) begin
        st_d.burst_on = 1'b0;
      end else if (!bus.address_latch_n && bus.we_n) begin
        st_d.burst_addr = bus.addr;
        st_d.burst_on = 1'b1;
      end else if (st_q.burst_on && !bus.oe_n && bus.we_n) begin
        st_d.burst_addr = ADDR_W'(st_q.burst_addr + 1'b1);
      end
      // Command latches feed the mode machine; nothing here is memory mapped.
      if (wr_edge) begin
        st_d.cmd = bus.data_lines[7:0];
        st_d.cmd_addr = bus.addr;
        st_d.cmd_data = bus.data_lines;
        unique case (st_q.mode)
          fbd_pkg::FBD_MODE_READ: begin
            unique case (bus.data_lines[7:0])
              `FBD_CMD_PROGRAM: begin
                if (!busy) begin
                  st_d.mode = fbd_pkg::FBD_MODE_PROG_SETUP;
                end
              end
              `FBD_CMD_DYN_SET: st_d.dyn[sec_in] = 1'b1;
              `FBD_CMD_DYN_CLEAR: st_d.dyn[sec_in] = 1'b0;
              `FBD_CMD_PERS_SET: st_d.pers[sec_in] = 1'b1;
              default: st_d.mode = fbd_pkg::FBD_MODE_READ;
            endcase
          end
          fbd_pkg::FBD_MODE_PROG_SETUP: begin
            if (prot_of(bus.addr, st_q, bus.wp_n)) begin
              st_d.mode = fbd_pkg::FBD_MODE_READ;
            end else begin
              st_d.mode = fbd_pkg::FBD_MODE_BUSY;
              st_d.busy_cnt = PROG_CYCLES;
              st_d.busy_bank = bank_of(bus.addr);
            end
          end
          fbd_pkg::FBD_MODE_BUSY: st_d.mode = st_q.mode;
          fbd_pkg::FBD_MODE_RESET: st_d.mode = st_q.mode;
        endcase
      end
      // Output drive follows select, gate and strobe; pin reset low forces it off above.
      if (rd) begin
        st_d.dq_oe_n = 1'b0;
        // The narrow address leaves only the offset bits to carry the code.
        if (bus.id_voltage_address_bit_hv &&
            bus.addr[OFF_W-1:0] == OFF_W'(`FBD_PROT_LOW_ADDR)) begin
          st_d.dq_out = `FBD_ST_UNPROTECTED;
          st_d.dq_out[0] = st_q.pers[sec_in];
          st_d.dq_out[1] = st_q.dyn[sec_in];
        end else if (busy && bank_of(word_addr) == st_q.busy_bank) begin
          st_d.dq_out = `FBD_BUSY_WORD;
        end else begin
          st_d.dq_out = mem[word_addr];
        end
      end else begin
        st_d.dq_oe_n = 1'b1;
      end
    end
    st_d.rb_oe_n = !(st_d.mode == fbd_pkg::FBD_MODE_BUSY ||
                     st_d.mode == fbd_pkg::FBD_MODE_RESET);
    st_d.busy_out = !st_d.rb_oe_n;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{mode: fbd_pkg::FBD_MODE_READ, we_n_prev: 1'b1, dq_oe_n: 1'b1,
                rb_oe_n: 1'b1, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // Flash program only clears bits.
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem[st_q.cmd_addr] <= mem[st_q.cmd_addr] & st_q.cmd_data;
    end
  end

  assign bus.dev_dq_out = st_q.dq_out;
  assign bus.dev_dq_oe_n = st_q.dq_oe_n;
  assign bus.rb_out = 1'b0;
  assign bus.rb_oe_n = st_q.rb_oe_n;
  assign busy_q = st_q.busy_out;
  assign busy_bank_q = st_q.busy_bank;
  assign cmd_q = st_q.cmd;
endmodule

// [rtl/fbd_regs.svh]
// Purpose: Shared constants of the flash bus operation decoder and its host controller.
// Assumes: A 100 MHz core clock shared by both ends.
// Notes: Offsets are byte addresses of the host controller register port.
`ifndef FBD_REGS_SVH
`define FBD_REGS_SVH
`define FBD_CLK_PERIOD_NS 10
`define FBD_RESET_TIME_NS 500
`define FBD_RESET_CYCLES ((`FBD_RESET_TIME_NS + `FBD_CLK_PERIOD_NS - 1) / `FBD_CLK_PERIOD_NS)
`define FBD_CMD_PROGRAM 8'ha0
`define FBD_CMD_READ_RESET 8'hf0
`define FBD_CMD_DYN_SET 8'h60
`define FBD_CMD_DYN_CLEAR 8'h61
`define FBD_CMD_PERS_SET 8'h68
`define FBD_PROT_LOW_ADDR 8'h02
`define FBD_BUSY_WORD 32'hffff_ff00
`define FBD_ST_PROTECTED 32'h0000_0001
`define FBD_ST_UNPROTECTED 32'h0000_0000
`define FBD_REG_CTRL 5'h00
`define FBD_REG_ADDR 5'h04
`define FBD_REG_WDATA 5'h08
`define FBD_REG_GO 5'h0c
`define FBD_REG_RDATA 5'h10
`define FBD_REG_STATUS 5'h14
`define FBD_CTRL_RESET_BIT 0
`define FBD_CTRL_WP_BIT 1
`define FBD_CTRL_IDV_BIT 2
`define FBD_GO_READ 3'h1
`define FBD_GO_WRITE 3'h2
`define FBD_GO_BURST 3'h3
`define FBD_GO_SYNC_WRITE 3'h4
`define FBD_CTRL_RESET_VAL 3'h3
`endif

// [rtl/fbd_pkg.sv]
// Purpose: Types shared by both ends of the flash bus.
// Assumes: Constants come from fbd_regs.svh.
// Notes: None.
package fbd_pkg;
  typedef enum logic [1:0] {
    FBD_MODE_READ,
    FBD_MODE_PROG_SETUP,
    FBD_MODE_BUSY,
    FBD_MODE_RESET
  } fbd_mode_e;
  typedef enum logic [2:0] {
    FBD_H_IDLE,
    FBD_H_READ,
    FBD_H_ALATCH,
    FBD_H_WRITE,
    FBD_H_BLOAD,
    FBD_H_BADV
  } fbd_hstate_e;
endpackage

// [rtl/fbd_if.sv]
// Purpose: Pin level meeting point of the flash device end and the host end.
// Assumes: Both ends run on the same core clock.
// Notes: The shared data lines and the open-drain ready line are resolved here.
`timescale 1ns/1ns
interface fbd_if #(parameter int ADDR_W = 8);
  logic [ADDR_W-1:0] addr;
  logic ce_n;
  logic oe_n;
  logic we_n;
  logic reset_n;
  logic address_latch_n;
  logic id_voltage_address_bit_hv;
  logic wp_n;
  logic [31:0] host_dq_out;
  logic host_dq_oe_n;
  logic [31:0] dev_dq_out;
  logic dev_dq_oe_n;
  logic rb_out;
  logic rb_oe_n;
  logic [31:0] data_lines;
  logic ready_busy_out;
  // Device drive wins on the data lines; the host never drives while reading.
  assign data_lines = !dev_dq_oe_n ? dev_dq_out : host_dq_out;
  // Pull-up on the open-drain ready line.
  assign ready_busy_out = rb_oe_n ? 1'b1 : rb_out;
  modport device (
    input addr, ce_n, oe_n, we_n, reset_n, address_latch_n, id_voltage_address_bit_hv, wp_n,
    input data_lines,
    output dev_dq_out, dev_dq_oe_n, rb_out, rb_oe_n
  );
  modport host (
    output addr, ce_n, oe_n, we_n, reset_n, address_latch_n, id_voltage_address_bit_hv, wp_n,
    output host_dq_out, host_dq_oe_n,
    input data_lines, ready_busy_out
  );
endinterface

// [rtl/fbd_host.sv]
// Purpose: Host end: turns register orders into flash bus cycles.
// Assumes: Software keeps program cycles in the small bank while reading the big one.
// Notes: Go orders are refused while a cycle is running; control, address and write-data writes are taken at once.
`timescale 1ns/1ns
`include "fbd_regs.svh"
module fbd_host #(
  parameter int ADDR_W = 8,
  parameter logic [7:0] BURST_LEN = 8'h04
) (
  input wire logic core_clk,
  input wire logic rst_b,
  fbd_if.host bus,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  typedef struct packed {
    fbd_pkg::fbd_hstate_e state;
    logic [2:0] ctrl;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [7:0] cnt;
    logic [31:0] rd_out;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic alatch_n;
    logic dq_oe_n;
  } fbd_host_s;

  fbd_host_s st_q;
  fbd_host_s st_d;
  logic idle;

  always_comb begin
    st_d = st_q;
    idle = st_q.state == fbd_pkg::FBD_H_IDLE;
    st_d.rd_out = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        `FBD_REG_CTRL: st_d.rd_out = {29'h0, st_q.ctrl};
        `FBD_REG_ADDR: st_d.rd_out = 32'(st_q.addr);
        `FBD_REG_WDATA: st_d.rd_out = st_q.wdata;
        `FBD_REG_RDATA: st_d.rd_out = st_q.rdata;
        `FBD_REG_STATUS: st_d.rd_out = {16'h0, st_q.cnt, 6'h0, bus.ready_busy_out, !idle};
        default: st_d.rd_out = '0;
      endcase
    end
    if (reg_wr) begin
      unique case (reg_addr)
        `FBD_REG_CTRL: st_d.ctrl = reg_wdata[2:0];
        `FBD_REG_ADDR: st_d.addr = reg_wdata[ADDR_W-1:0];
        `FBD_REG_WDATA: st_d.wdata = reg_wdata;
        `FBD_REG_GO: begin
          if (idle) begin
            st_d.cnt = '0;
            st_d.ce_n = 1'b0;
            unique case (reg_wdata[2:0])
              `FBD_GO_READ: begin
                st_d.oe_n = 1'b0;
                st_d.state = fbd_pkg::FBD_H_READ;
              end
              `FBD_GO_WRITE: begin
                st_d.we_n = 1'b0;
                st_d.dq_oe_n = 1'b0;
                st_d.state = fbd_pkg::FBD_H_WRITE;
              end
              `FBD_GO_BURST: begin
                st_d.alatch_n = 1'b0;
                st_d.state = fbd_pkg::FBD_H_BLOAD;
              end
              `FBD_GO_SYNC_WRITE: begin
                st_d.alatch_n = 1'b0;
                st_d.state = fbd_pkg::FBD_H_ALATCH;
              end
              default: st_d.ce_n = 1'b1;
            endcase
          end
        end
        default: st_d.ctrl = st_q.ctrl;
      endcase
    end
    unique case (st_q.state)
      fbd_pkg::FBD_H_IDLE: st_d.cnt = st_d.cnt;
      fbd_pkg::FBD_H_READ: begin
        st_d.cnt = st_q.cnt + 8'h01;
        if (st_q.cnt == 8'h01) begin
          st_d.rdata = bus.data_lines;
          st_d.ce_n = 1'b1;
          st_d.oe_n = 1'b1;
          st_d.state = fbd_pkg::FBD_H_IDLE;
        end
      end
      fbd_pkg::FBD_H_ALATCH: begin
        st_d.alatch_n = 1'b1;
        st_d.we_n = 1'b0;
        st_d.dq_oe_n = 1'b0;
        st_d.state = fbd_pkg::FBD_H_WRITE;
      end
      fbd_pkg::FBD_H_WRITE: begin
        st_d.ce_n = 1'b1;
        st_d.we_n = 1'b1;
        st_d.dq_oe_n = 1'b1;
        st_d.state = fbd_pkg::FBD_H_IDLE;
      end
      fbd_pkg::FBD_H_BLOAD: begin
        st_d.alatch_n = 1'b1;
        st_d.oe_n = 1'b0;
        st_d.state = fbd_pkg::FBD_H_BADV;
      end
      fbd_pkg::FBD_H_BADV: begin
        st_d.cnt = st_q.cnt + 8'h01;
        if (st_q.cnt != 8'h00) begin
          st_d.rdata = bus.data_lines;
        end
        if (st_q.cnt == BURST_LEN) begin
          st_d.ce_n = 1'b1;
          st_d.oe_n = 1'b1;
          st_d.state = fbd_pkg::FBD_H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{state: fbd_pkg::FBD_H_IDLE, ctrl: `FBD_CTRL_RESET_VAL, ce_n: 1'b1, oe_n: 1'b1,
                we_n: 1'b1, alatch_n: 1'b1, dq_oe_n: 1'b1, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign bus.addr = st_q.addr;
  assign bus.ce_n = st_q.ce_n;
  assign bus.oe_n = st_q.oe_n;
  assign bus.we_n = st_q.we_n;
  assign bus.address_latch_n = st_q.alatch_n;
  assign bus.reset_n = st_q.ctrl[`FBD_CTRL_RESET_BIT];
  assign bus.wp_n = st_q.ctrl[`FBD_CTRL_WP_BIT];
  assign bus.id_voltage_address_bit_hv = st_q.ctrl[`FBD_CTRL_IDV_BIT];
  assign bus.host_dq_out = st_q.wdata;
  assign bus.host_dq_oe_n = st_q.dq_oe_n;
  assign reg_rdata = st_q.rd_out;
endmodule

// [dv/fbd_checker.sv]
// Purpose: Pin level checks on the bus joining the flash host and device ends.
// Assumes: Both ends share core_clk; rst_b is asynchronous, active low.
// Notes: Device outputs follow the pins one clock later.
`timescale 1ns/1ns
module fbd_checker (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic reset_n,
  input wire logic address_latch_n,
  input wire logic host_dq_oe_n,
  input wire logic dev_dq_oe_n,
  input wire logic ready_busy_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  AST_STANDBY_FLOAT: assert property (ce_n |=> dev_dq_oe_n)
    else $error("device drives while deselected");
  AST_RESET_FLOAT: assert property (!reset_n |=> dev_dq_oe_n)
    else $error("device drives during pin reset");
  AST_OUT_DISABLE: assert property (!ce_n && oe_n && we_n |=> dev_dq_oe_n)
    else $error("device drives with output gate high");
  AST_READ_DRIVE: assert property (!ce_n && !oe_n && we_n && reset_n |=> !dev_dq_oe_n)
    else $error("device silent in a read cycle");
  AST_WRITE_LEVELS: assert property (!host_dq_oe_n |-> !ce_n && !we_n && oe_n)
    else $error("host drives data outside a write cycle");
  AST_NO_FIGHT: assert property (!dev_dq_oe_n |-> host_dq_oe_n)
    else $error("both ends drive the data lines");
  AST_LOAD_LEVELS: assert property (!address_latch_n |-> !ce_n && we_n)
    else $error("address latch outside a selected cycle");
  AST_RB_PULL: assert property ($fell(reset_n) |-> ##[1:2] !ready_busy_out)
    else $error("ready not pulled low by pin reset");
  AST_RB_HOLD: assert property ($rose(reset_n) |-> (!ready_busy_out) [*8])
    else $error("ready released too early after pin reset");
  AST_RB_BOUND: assert property ($fell(ready_busy_out) |-> ##[1:200] ready_busy_out)
    else $error("ready stuck low");
endmodule

// [dv/tb_top.sv]
// Purpose: Self-checking bench for the flash host and device ends joined by the bus.
// Assumes: Program time shortened to 32 cycles; array words start unknown, so only zeros
//   are programmed and read back.
// Notes: Expected read words are queued by the driver and compared by a monitor.
`timescale 1ns/1ns
`include "fbd_regs.svh"
module tb_top;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic busy_q;
  logic busy_bank_q;
  logic [7:0] cmd_q;
  logic rd_q = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] mask_q[$];
  logic [31:0] seed = 32'h2f1c;
  logic [7:0] base;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  fbd_if #(.ADDR_W(8)) bus_if();
  fbd_device #(.PROG_CYCLES(16'h0020)) i_fbd_device (.core_clk(core_clk), .rst_b(rst_b),
    .bus(bus_if), .busy_q(busy_q), .busy_bank_q(busy_bank_q), .cmd_q(cmd_q));
  fbd_host i_fbd_host (.core_clk(core_clk), .rst_b(rst_b), .bus(bus_if), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  fbd_checker i_fbd_checker (.core_clk(core_clk), .rst_b(rst_b), .ce_n(bus_if.ce_n),
    .oe_n(bus_if.oe_n), .we_n(bus_if.we_n), .reset_n(bus_if.reset_n),
    .address_latch_n(bus_if.address_latch_n), .host_dq_oe_n(bus_if.host_dq_oe_n),
    .dev_dq_oe_n(bus_if.dev_dq_oe_n), .ready_busy_out(bus_if.ready_busy_out));
  always #5 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic summarize();
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_dev(input logic [9:0] e);
    @(negedge core_clk);
    chk({22'h0, busy_q, busy_bank_q, cmd_q}, {22'h0, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    mask_q.push_back(m);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic go(input logic [7:0] a, input logic [31:0] d, input logic [2:0] k, input int n);
    wr(`FBD_REG_ADDR, {24'h0, a});
    wr(`FBD_REG_WDATA, d);
    wr(`FBD_REG_GO, {29'h0, k});
    cyc(n);
  endtask
  task automatic wait_ready();
    int i;
    for (i = 0; i < 300 && bus_if.ready_busy_out !== 1'b1; i++) begin
      @(posedge core_clk);
    end
    if (i == 300) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, bus_if.ready_busy_out, 1'b1);
    end
  endtask
  task automatic prog(input logic [7:0] a, input logic [31:0] d);
    go(a, {24'h0, `FBD_CMD_PROGRAM}, `FBD_GO_WRITE, 3);
    go(a, d, `FBD_GO_WRITE, 3);
  endtask
  task automatic prot(input logic [2:0] s, input logic [31:0] e);
    wr(`FBD_REG_CTRL, 32'h7);
    go({s, 5'h02}, 0, `FBD_GO_READ, 6);
    rd(`FBD_REG_RDATA, e, 32'hffff_ffff);
    wr(`FBD_REG_CTRL, 32'h3);
  endtask
  // Read data stand only in the cycle after the strobe, so look mid-cycle then.
  always @(posedge core_clk) rd_q <= reg_rd;
  always @(negedge core_clk) begin
    if (rd_q) begin
      chk(reg_rdata & mask_q.pop_front(), exp_q.pop_front());
    end
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    cyc(16);
    rst_b <= 1'b1;
    seed = lfsr_next(seed);
    base = {2'b01, seed[3:0], 2'b00};
    for (int i = 0; i < 4; i++) begin
      prog(base + 8'(i), 32'h0);
      wait_ready();
    end
    go(base, 0, `FBD_GO_READ, 6);
    rd(`FBD_REG_RDATA, 32'h0, 32'hffff_ffff);
    go(base, 0, `FBD_GO_BURST, 14);
    rd(`FBD_REG_RDATA, 32'h0, 32'hffff_ffff);
    rd(`FBD_REG_STATUS, 32'h0000_0502, 32'h0000_ff03);
    rd(5'h1c, 32'h0, 32'hffff_ffff);
    prot(3'h5, `FBD_ST_UNPROTECTED);
    go(8'ha0, {24'h0, `FBD_CMD_DYN_SET}, `FBD_GO_SYNC_WRITE, 3);
    chk_dev({1'b0, 1'b1, `FBD_CMD_DYN_SET});
    prot(3'h5, 32'h2);
    go(8'ha0, {24'h0, `FBD_CMD_PERS_SET}, `FBD_GO_WRITE, 3);
    prot(3'h5, 32'h3);
    wr(`FBD_REG_CTRL, 32'h2);
    cyc(6);
    rd(`FBD_REG_STATUS, 32'h0, 32'h2);
    wr(`FBD_REG_CTRL, 32'h3);
    wait_ready();
    prot(3'h5, `FBD_ST_PROTECTED);
    prog(8'ha1, 32'h0);
    rd(`FBD_REG_STATUS, 32'h2, 32'h2);
    wr(`FBD_REG_CTRL, 32'h1);
    prog(8'he1, 32'h0);
    rd(`FBD_REG_STATUS, 32'h2, 32'h2);
    wr(`FBD_REG_CTRL, 32'h3);
    prog(8'h21, 32'h0);
    chk_dev({1'b1, 1'b0, 8'h00});
    rd(`FBD_REG_STATUS, 32'h0, 32'h2);
    go(8'h22, 0, `FBD_GO_READ, 6);
    rd(`FBD_REG_RDATA, `FBD_BUSY_WORD, 32'hffff_ffff);
    go(base, 0, `FBD_GO_READ, 6);
    rd(`FBD_REG_RDATA, 32'h0, 32'hffff_ffff);
    wait_ready();
    cyc(4);
    summarize();
  end
endmodule
